// *** core/scai_pulse.sv ***
// scai_pulse: fixed-width pulse timer for edge-type interrupts.
// assumes start and cancel are one-cycle strobes; cancel wins.
`timescale 1ns/1ps
module scai_pulse
   import scai_pkg::*;
#(
   parameter int LENGTH = PULSE_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic cancel,
   // state
   output logic busy
);
   localparam int CW = $clog2(LENGTH + 1);
   localparam logic [CW-1:0] LEN = CW'(LENGTH);
   logic [CW-1:0] cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (cancel) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= LEN;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
   assign busy = (cnt_q != '0);
endmodule

// *** core/scai_status.sv ***
// scai_status: sticky status bits, one flip-flop per bit set in MASK; the other bits read zero.
// assumes set and clear vectors are single-cycle and synchronous.
`timescale 1ns/1ps
module scai_status
   import scai_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] MASK = STATUS_MASK
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic wipe,
   input wire logic [WIDTH-1:0] set_bits,
   input wire logic [WIDTH-1:0] clr_bits,
   // state
   output logic [WIDTH-1:0] status_q
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         if (MASK[i]) begin : g_live
            // set beats clear so no event is lost on a read
            always_ff @(posedge clk or negedge rst_n) begin
               if (!rst_n) begin
                  status_q[i] <= 1'b0;
               end else if (set_bits[i]) begin
                  status_q[i] <= 1'b1;
               end else if (wipe || clr_bits[i]) begin
                  status_q[i] <= 1'b0;
               end
            end
         end else begin : g_rsvd
            assign status_q[i] = 1'b0;
         end
      end
   endgenerate
endmodule

// *** core/scai_top.sv ***
// scai_top: system control registers and the interrupt combiner.
// assumes the serial front end presents one decoded byte access per strobe,
// and that the engines present events as one-cycle pulses.
`timescale 1ns/1ps
module scai_top
   import scai_pkg::*;
#(
   parameter logic [15:0] CHIP_IDENTITY = 16'h5A5A, // arbitrary value
   parameter logic [7:0] REVISION_NUMBER = 8'h01, // arbitrary value
   parameter int PULSE_LEN = PULSE_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register access from the serial front end
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_ack,
   output logic reg_refused,
   output logic reg_ext_sel,
   // events from the engines
   input wire logic ev_touch_detected,
   input wire logic ev_touch_data_ready,
   input wire logic ev_pin0_activity,
   input wire logic ev_pin1_activity,
   input wire logic ev_pin2_activity,
   input wire logic ev_touch_release,
   input wire logic ev_touch_error,
   input wire logic pen_down,
   input wire logic touch_data_read,
   input wire logic acq_mode,
   // system control outputs
   output logic soft_reset,
   output logic touch_engine_enable,
   output logic [3:0] clk_gate,
   output logic [1:0] pin0_role,
   output logic [1:0] pin1_role,
   output logic [1:0] pin2_role,
   output logic pin1_pwm_route,
   output logic pin2_int_route,
   // interrupt pin
   output logic int_out
);
   logic [7:0] system_control_q;
   logic [7:0] pin_role_q;
   logic [15:0] scratch_q;
   logic [7:0] int_ctrl_q;
   logic [7:0] int_en_q;
   logic [7:0] status_q;
   logic srst_q;
   logic [7:0] ev_bits;
   logic [7:0] set_bits;
   logic [7:0] clr_bits;
   logic [7:0] rd_d;
   logic wr_sys, wr_role, wr_ctrl, wr_en;
   logic rd_status, rd_en;
   logic mode_change;
   logic gated_d, ext_d;
   logic pen_mode, edge_type, pulse_busy, pulse_start;
   logic int_active;

   // access decode
   assign wr_sys = reg_wr && (reg_addr == OFS_SYSTEM_CONTROL);
   assign wr_role = reg_wr && (reg_addr == OFS_PIN_ROLE);
   assign wr_ctrl = reg_wr && (reg_addr == OFS_INT_CTRL);
   assign wr_en = reg_wr && (reg_addr == OFS_INT_EN);
   assign rd_status = reg_rd && (reg_addr == OFS_INT_STATUS);
   assign rd_en = reg_rd && (reg_addr == OFS_INT_EN);

   // gated windows; the low window has no gate at all
   always_comb begin
      gated_d = 1'b0;
      ext_d = 1'b0;
      unique case (reg_addr[7:4])
         WIN_PORT_IO: gated_d = system_control_q[SC_GATE_PORT];
         WIN_CONVERTER: gated_d = system_control_q[SC_GATE_CONV];
         WIN_TOUCH: gated_d = system_control_q[SC_GATE_TOUCH];
         WIN_PULSE_WIDTH: gated_d = system_control_q[SC_GATE_PWM];
         4'h0: ext_d = 1'b0;
         default: ext_d = 1'b0;
      endcase
      if (reg_addr[7:4] != 4'h0 && !gated_d) begin
         ext_d = 1'b1;
      end
   end

   // soft reset strobe, one cycle after the write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= wr_sys && reg_wdata[SC_SOFT_RESET];
      end
   end

   // system control and pin roles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         system_control_q <= SYSTEM_CONTROL_RST;
         pin_role_q <= PIN_ROLE_RST;
      end else if (srst_q) begin
         system_control_q <= SYSTEM_CONTROL_RST;
         pin_role_q <= PIN_ROLE_RST;
      end else begin
         if (wr_sys && !reg_wdata[SC_SOFT_RESET]) begin
            system_control_q <= reg_wdata & SYSTEM_CONTROL_WMASK;
         end
         if (wr_role) begin
            pin_role_q <= (reg_wdata & PIN_ROLE_WMASK) | ~PIN_ROLE_WMASK;
         end
      end
   end

   // scratch storage; no side effects on either access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scratch_q <= SCRATCH_RST;
      end else if (srst_q) begin
         scratch_q <= SCRATCH_RST;
      end else if (reg_wr && reg_addr == OFS_SCRATCH_LO) begin
         scratch_q[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == OFS_SCRATCH_HI) begin
         scratch_q[15:8] <= reg_wdata;
      end
   end

   // interrupt control and enable mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_ctrl_q <= INT_CTRL_RST;
         int_en_q <= INT_EN_RST;
      end else if (srst_q) begin
         int_ctrl_q <= INT_CTRL_RST;
         int_en_q <= INT_EN_RST;
      end else begin
         if (wr_ctrl) begin
            int_ctrl_q <= reg_wdata & INT_CTRL_WMASK;
         end
         if (wr_en) begin
            int_en_q <= reg_wdata & STATUS_MASK;
         end
      end
   end

   assign pen_mode = !int_ctrl_q[IC_MODE];
   assign edge_type = int_ctrl_q[IC_TYPE] && !pen_mode;
   assign mode_change = wr_ctrl && (reg_wdata[IC_MODE] != int_ctrl_q[IC_MODE]);

   // status sources and clears
   always_comb begin
      ev_bits = '0;
      ev_bits[ST_TOUCH_DETECTED] = ev_touch_detected || (pen_mode && pen_down);
      ev_bits[ST_TOUCH_DATA_READY] = ev_touch_data_ready;
      ev_bits[ST_PIN0_ACTIVITY] = ev_pin0_activity;
      ev_bits[ST_PIN1_ACTIVITY] = ev_pin1_activity;
      ev_bits[ST_PIN2_ACTIVITY] = ev_pin2_activity;
      ev_bits[ST_TOUCH_RELEASE] = ev_touch_release;
      ev_bits[ST_TOUCH_ERROR] = ev_touch_error;
      set_bits = ev_bits & STATUS_MASK;
      // only bits captured by this read are cleared; later events survive
      clr_bits = '0;
      if (rd_status) begin
         clr_bits = status_q;
      end
      if (rd_en) begin
         clr_bits = status_q;
      end
      // data ready follows the acquisition mode
      if (!acq_mode) begin
         clr_bits[ST_TOUCH_DATA_READY] = 1'b0;
      end
      if (touch_data_read) begin
         clr_bits[ST_TOUCH_DATA_READY] = 1'b1;
      end
   end

   scai_status #(
      .WIDTH(8),
      .MASK(STATUS_MASK)
   ) u_status (
      .clk(clk),
      .rst_n(rst_n),
      .wipe(srst_q || mode_change),
      .set_bits(set_bits),
      .clr_bits(clr_bits),
      .status_q(status_q)
   );

   // edge type: a newly set enabled bit starts or restarts the pulse, a held bit does not
   assign pulse_start = edge_type
      && |(set_bits & ~status_q & int_en_q);

   scai_pulse #(
      .LENGTH(PULSE_LEN)
   ) u_pulse (
      .clk(clk),
      .rst_n(rst_n),
      .start(pulse_start),
      .cancel(srst_q || mode_change),
      .busy(pulse_busy)
   );

   // interrupt combiner
   always_comb begin
      int_active = 1'b0;
      if (pen_mode) begin
         // pen level, plus any other enabled pending sources
         int_active = (pen_down && int_en_q[ST_TOUCH_DETECTED])
            || |(status_q & int_en_q & ~8'h01);
      end else if (edge_type) begin
         int_active = pulse_busy;
      end else begin
         int_active = |(status_q & int_en_q);
      end
      if (!int_ctrl_q[IC_GLOBAL]) begin
         int_active = 1'b0;
      end
   end

   // pin level; polarity zero means active low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_out <= 1'b1;
      end else begin
         int_out <= int_active ~^ int_ctrl_q[IC_POLARITY];
      end
   end

   // read data mux
   always_comb begin
      rd_d = 8'h00;
      unique case (reg_addr)
         OFS_ID_HI: rd_d = CHIP_IDENTITY[15:8];
         OFS_ID_LO: rd_d = CHIP_IDENTITY[7:0];
         OFS_REV: rd_d = REVISION_NUMBER;
         OFS_SYSTEM_CONTROL: rd_d = system_control_q;
         OFS_PIN_ROLE: rd_d = pin_role_q;
         OFS_SCRATCH_LO: rd_d = scratch_q[7:0];
         OFS_SCRATCH_HI: rd_d = scratch_q[15:8];
         OFS_INT_CTRL: rd_d = int_ctrl_q;
         OFS_INT_EN: rd_d = int_en_q;
         OFS_INT_STATUS: rd_d = status_q;
         default: rd_d = 8'h00;
      endcase
   end

   // bus answer, one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_ack <= 1'b0;
         reg_refused <= 1'b0;
         reg_ext_sel <= 1'b0;
      end else begin
         reg_ack <= reg_rd || reg_wr;
         reg_rdata <= reg_rd ? rd_d : 8'h00;
         reg_refused <= (reg_rd || reg_wr) && gated_d;
         reg_ext_sel <= (reg_rd || reg_wr) && ext_d;
      end
   end

   // registered mirrors of control state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_reset <= 1'b0;
         touch_engine_enable <= 1'b0;
         clk_gate <= 4'hF;
         pin0_role <= 2'h0;
         pin1_role <= 2'h2;
         pin2_role <= 2'h3;
         pin1_pwm_route <= 1'b0;
         pin2_int_route <= 1'b1;
      end else begin
         soft_reset <= srst_q;
         touch_engine_enable <= system_control_q[SC_ENGINE_EN];
         clk_gate <= system_control_q[3:0];
         pin0_role <= pin_role_q[ROLE_P0_LSB +: 2];
         pin1_role <= pin_role_q[ROLE_P1_LSB +: 2];
         pin2_role <= pin_role_q[ROLE_P2_LSB +: 2];
         pin1_pwm_route <= pin_role_q[ROLE_P1_LSB +: 2] == ROLE_SPECIAL;
         pin2_int_route <= pin_role_q[ROLE_P2_LSB +: 2] == ROLE_SPECIAL;
      end
   end

   // checks
   localparam int resp_max = PORT_RESP_CYC;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_soft_reset_all: assert property (
      wr_sys && reg_wdata[SC_SOFT_RESET] |=> srst_q ##1
         (int_ctrl_q == INT_CTRL_RST && system_control_q == SYSTEM_CONTROL_RST
          && scratch_q == SCRATCH_RST && soft_reset))
      else $error("soft reset did not restore registers");

   a_engine_follow: assert property (
      wr_sys && !reg_wdata[SC_SOFT_RESET] |=> ##1
         touch_engine_enable == $past(reg_wdata[SC_ENGINE_EN], 2))
      else $error("engine enable does not follow write");

   a_gate_refuse: assert property (
      reg_rd && reg_addr[7:4] == WIN_TOUCH && system_control_q[SC_GATE_TOUCH]
         |=> reg_refused && !reg_ext_sel)
      else $error("gated touch registers were reachable");

   a_low_open: assert property (
      (reg_rd || reg_wr) && reg_addr[7:4] == 4'h0 |=> reg_ack && !reg_refused)
      else $error("low window refused");

   a_pen_hold: assert property (
      pen_mode && int_ctrl_q[IC_GLOBAL] && int_en_q[0] && pen_down
         |=> int_out == $past(int_ctrl_q[IC_POLARITY]))
      else $error("pen down not held on pin");

   a_normal_level: assert property (
      !pen_mode && !int_ctrl_q[IC_TYPE] && int_ctrl_q[IC_GLOBAL]
         && |(status_q & int_en_q) |=> int_out == $past(int_ctrl_q[IC_POLARITY]))
      else $error("pending status not shown on pin");

   a_global_block: assert property (
      !int_ctrl_q[IC_GLOBAL] |=> int_out == !$past(int_ctrl_q[IC_POLARITY]))
      else $error("interrupt escaped master enable");

   a_mode_clear: assert property (
      mode_change && set_bits == 8'h00 |=> status_q == 8'h00 && !pulse_busy)
      else $error("mode change left status or pulse");

   a_status_wr: assert property (
      reg_wr && reg_addr == OFS_INT_STATUS && !rd_status && set_bits == 8'h00
         && !touch_data_read && !srst_q |=> status_q == $past(status_q))
      else $error("status write had an effect");

   a_pen_touch_keep: assert property (
      pen_mode && pen_down && !mode_change && !srst_q |=> status_q[ST_TOUCH_DETECTED])
      else $error("touch bit cleared while pen down");

   a_pulse_width: assert property (
      pulse_start && !mode_change && !srst_q |=> pulse_busy [*8])
      else $error("edge pulse too short");

   a_port_resp: assert property (
      !pen_mode && !int_ctrl_q[IC_TYPE] && int_ctrl_q[IC_GLOBAL]
         && int_en_q[ST_PIN0_ACTIVITY] && ev_pin0_activity && !wr_ctrl && !wr_en
         && !srst_q |-> ##[1:resp_max] int_out == int_ctrl_q[IC_POLARITY])
      else $error("port activity too slow");

   c_pen_int: cover property (pen_mode && pen_down && int_active);
   c_edge_pulse: cover property (pulse_start ##1 pulse_busy);
   c_read_clear: cover property (rd_status && |status_q ##1 status_q == 8'h00);
   c_gated: cover property (reg_refused);
endmodule

// *** shared/scai_pkg.sv ***
// scai_pkg: register map, field positions, reset values and timing counts
// of the system control and interrupt block.
// assumes a 10 MHz register clock; the serial link front end decodes bytes.
// How it works
// - soft reset bit restores all registers, states
// - engine enable bit switches touch operation
// - four clock gate bits, reset to one
// - gated function registers refuse host access
// - two-bit role per port in role register
// - role 11: pwm on port1, irq port2
// - pen mode holds interrupt while pen down
// - pen mode output ORs other enabled interrupts
// - normal mode asserts on any enabled status
// - mode change clears status and pending pulse
// - polarity bit picks high or low activity
// - type bit selects pulse or level output
// - pen mode ignores type, never pulses
// - master enable zero blocks every interrupt
// - enable and status share one bit layout
// - status records events regardless of enables
// - status writes ignored, read clears read bits
// - enable register read also clears status
// - data ready clears per acquisition mode
// - pen mode keeps touch bit until lift
// - port activity reaches pin within 5 us
// - sixteen bit scratch register, no side effects
// - offsets 0x00-0x0F always accessible
package scai_pkg;
   // offsets
   localparam logic [7:0] OFS_ID_HI = 8'h00;
   localparam logic [7:0] OFS_ID_LO = 8'h01;
   localparam logic [7:0] OFS_REV = 8'h02;
   localparam logic [7:0] OFS_SYSTEM_CONTROL = 8'h03;
   localparam logic [7:0] OFS_PIN_ROLE = 8'h04;
   localparam logic [7:0] OFS_SCRATCH_LO = 8'h06;
   localparam logic [7:0] OFS_SCRATCH_HI = 8'h07;
   localparam logic [7:0] OFS_INT_CTRL = 8'h08;
   localparam logic [7:0] OFS_INT_EN = 8'h09;
   localparam logic [7:0] OFS_INT_STATUS = 8'h0A;
   // gated windows, upper address nibble
   localparam logic [3:0] WIN_PORT_IO = 4'h1;
   localparam logic [3:0] WIN_CONVERTER = 4'h2;
   localparam logic [3:0] WIN_TOUCH = 4'h4;
   localparam logic [3:0] WIN_PULSE_WIDTH = 4'h5;
   // system control fields
   localparam int SC_SOFT_RESET = 6;
   localparam int SC_ENGINE_EN = 5;
   localparam int SC_GATE_PWM = 3;
   localparam int SC_GATE_PORT = 2;
   localparam int SC_GATE_TOUCH = 1;
   localparam int SC_GATE_CONV = 0;
   localparam logic [7:0] SYSTEM_CONTROL_WMASK = 8'h2F;
   // pin role fields and codes
   localparam int ROLE_P2_LSB = 6;
   localparam int ROLE_P1_LSB = 2;
   localparam int ROLE_P0_LSB = 0;
   localparam logic [7:0] PIN_ROLE_WMASK = 8'hCF;
   localparam logic [1:0] ROLE_SPECIAL = 2'h3;
   // interrupt control fields
   localparam int IC_MODE = 7;
   localparam int IC_POLARITY = 2;
   localparam int IC_TYPE = 1;
   localparam int IC_GLOBAL = 0;
   localparam logic [7:0] INT_CTRL_WMASK = 8'h87;
   // status and enable layout
   localparam int ST_TOUCH_DETECTED = 0;
   localparam int ST_TOUCH_DATA_READY = 1;
   localparam int ST_PIN0_ACTIVITY = 2;
   localparam int ST_PIN1_ACTIVITY = 3;
   localparam int ST_PIN2_ACTIVITY = 5;
   localparam int ST_TOUCH_RELEASE = 6;
   localparam int ST_TOUCH_ERROR = 7;
   localparam logic [7:0] STATUS_MASK = 8'hEF;
   // reset values
   localparam logic [7:0] SYSTEM_CONTROL_RST = 8'h0F;
   localparam logic [7:0] PIN_ROLE_RST = 8'hF8;
   localparam logic [15:0] SCRATCH_RST = 16'h0000;
   localparam logic [7:0] INT_CTRL_RST = 8'h00;
   localparam logic [7:0] INT_EN_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int PULSE_MIN_US = 50;
   localparam int PULSE_MAX_US = 150;
   localparam int PULSE_CYC = (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PORT_RESP_US = 5;
   localparam int PORT_RESP_CYC = (PORT_RESP_US * 1000) / CLK_PERIOD_NS;
endpackage

// *** tb/scai_host.sv ***
// scai_host: host model on the decoded register port.
// assumes strobes launch at the falling edge, one access at a time.
`timescale 1ns/1ps
module scai_host (
   // clock
   input wire logic clk,
   // register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_refused,
   input wire logic reg_ext_sel
);
   logic [7:0] data_q;
   logic refused_q;
   logic ext_q;
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // strobe is a one-cycle pulse; answer awaited for at most four cycles
   task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
      int i;
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // released lines show the inverse, so no stale value looks valid
      reg_addr = ~a;
      reg_wdata = ~d;
      for (i = 0; i < 4 && reg_ack !== 1'b1; i++) @(negedge clk);
      data_q = reg_rdata;
      refused_q = reg_refused;
      ext_q = reg_ext_sel;
   endtask
endmodule

// *** tb/tb.sv ***
// tb: self-checking bench for the system control and interrupt block.
// assumes the host model in scai_host; events come from the bench.
`timescale 1ns/1ps
module tb;
   import scai_pkg::*;
   // full width, so the pulse is judged against its real floor
   localparam int PLEN = PULSE_CYC;
   logic clk, rst_n, pen_down, touch_data_read, acq_mode;
   logic [7:0] ev, addr, wdata, rdata;
   logic wr, rd, ack, refused, ext_sel, soft_reset, tee, p1r, p2r, int_out;
   logic [3:0] clk_gate;
   logic [1:0] r0, r1, r2;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   scai_host host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
      .reg_rdata(rdata), .reg_ack(ack), .reg_refused(refused), .reg_ext_sel(ext_sel));
   scai_top #(.PULSE_LEN(PLEN)) DUT (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
      .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack),
      .reg_refused(refused), .reg_ext_sel(ext_sel), .ev_touch_detected(ev[0]),
      .ev_touch_data_ready(ev[1]), .ev_pin0_activity(ev[2]), .ev_pin1_activity(ev[3]),
      .ev_pin2_activity(ev[5]), .ev_touch_release(ev[6]), .ev_touch_error(ev[7]),
      .pen_down(pen_down), .touch_data_read(touch_data_read), .acq_mode(acq_mode),
      .soft_reset(soft_reset), .touch_engine_enable(tee), .clk_gate(clk_gate),
      .pin0_role(r0), .pin1_role(r1), .pin2_role(r2), .pin1_pwm_route(p1r),
      .pin2_int_route(p2r), .int_out(int_out));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic finish_test();
      if (n_mismatch == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // sized for the scenarios below with ample margin
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      host.access(a, 1'b1, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host.access(a, 1'b0, 8'h00);
      chk(host.data_q, exp, "read");
   endtask
   task automatic fire(input logic [7:0] m);
      @(negedge clk);
      ev = m;
      @(negedge clk);
      ev = 8'h00;
   endtask
   // waits a bounded number of cycles for the pin level, then judges it
   task automatic wait_int(input logic v, input int n);
      for (int i = 0; i < n && int_out !== v; i++) @(negedge clk);
      chk(8'(int_out), 8'(v), "int pin");
   endtask
   task automatic t_reset();
      chk(8'(clk_gate), 8'h0F, "gates");
      chk(8'({p2r, p1r}), 8'h02, "routes");
      chk(8'(int_out), 8'h01, "idle pin");
      rd_chk(OFS_SYSTEM_CONTROL, 8'h0F);
      rd_chk(OFS_PIN_ROLE, 8'hF8);
      rd_chk(OFS_SCRATCH_LO, 8'h00);
      rd_chk(OFS_INT_CTRL, 8'h00);
      rd_chk(OFS_INT_STATUS, 8'h00);
      chk(8'(host.refused_q), 8'h00, "low refused");
   endtask
   task automatic t_gate_scratch();
      wr_reg(8'h10, 8'h01);
      chk(8'(host.refused_q), 8'h01, "gated port");
      rd_chk(8'h40, 8'h00);
      chk(8'(host.refused_q), 8'h01, "gated touch");
      wr_reg(OFS_SYSTEM_CONTROL, 8'h20);
      rd_chk(OFS_SYSTEM_CONTROL, 8'h20);
      chk(8'({tee, clk_gate}), 8'h10, "enable, gates");
      rd_chk(8'h10, 8'h00);
      chk(8'({host.refused_q, host.ext_q}), 8'h01, "open port");
      wr_reg(OFS_SCRATCH_LO, 8'hA5);
      wr_reg(OFS_SCRATCH_HI, 8'h3C);
      rd_chk(OFS_SCRATCH_LO, 8'hA5);
      rd_chk(OFS_SCRATCH_HI, 8'h3C);
   endtask
   task automatic t_role();
      wr_reg(OFS_PIN_ROLE, 8'hC7);
      rd_chk(OFS_PIN_ROLE, 8'hF7);
      chk(8'({r2, r1, r0}), 8'h37, "roles");
      chk(8'({p2r, p1r}), 8'h02, "routes");
      wr_reg(OFS_PIN_ROLE, 8'h0C);
      // route mirrors lag the register by one edge
      @(negedge clk);
      chk(8'({p2r, p1r}), 8'h01, "routes");
   endtask
   task automatic t_level();
      wr_reg(OFS_INT_CTRL, 8'h85);
      wr_reg(OFS_INT_EN, 8'h04);
      fire(8'h80);
      repeat (4) @(negedge clk);
      chk(8'(int_out), 8'h00, "masked event");
      fire(8'h04);
      wait_int(1'b1, 50);
      rd_chk(OFS_INT_STATUS, 8'h84);
      wait_int(1'b0, 3);
      wr_reg(OFS_INT_STATUS, 8'hFF);
      rd_chk(OFS_INT_STATUS, 8'h00);
      wr_reg(OFS_INT_CTRL, 8'h81);
      wait_int(1'b1, 3);
      wr_reg(OFS_INT_CTRL, 8'h84);
      fire(8'h04);
      repeat (5) @(negedge clk);
      chk(8'(int_out), 8'h00, "master off");
      // reading the enable register is an init-only habit of the host
      rd_chk(OFS_INT_EN, 8'h04);
      rd_chk(OFS_INT_STATUS, 8'h00);
   endtask
   task automatic t_edge();
      int n;
      wr_reg(OFS_INT_CTRL, 8'h87);
      fire(8'h04);
      wait_int(1'b1, 5);
      for (n = 0; n < 600 && int_out === 1'b1; n++) @(negedge clk);
      chk(8'(n == PLEN), 8'h01, "pulse width");
      repeat (5) @(negedge clk);
      chk(8'(int_out), 8'h00, "one pulse");
      rd_chk(OFS_INT_STATUS, 8'h04);
   endtask
   task automatic t_pen();
      wr_reg(OFS_INT_CTRL, 8'h03);
      // only the touch source enabled, so the pin means pen state alone
      wr_reg(OFS_INT_EN, 8'h01);
      pen_down = 1'b1;
      wait_int(1'b0, 5);
      repeat (30) @(negedge clk);
      chk(8'(int_out), 8'h00, "held, no pulse");
      rd_chk(OFS_INT_STATUS, 8'h01);
      pen_down = 1'b0;
      wait_int(1'b1, 5);
      wr_reg(OFS_INT_EN, 8'h05);
      fire(8'h04);
      wait_int(1'b0, 5);
      wr_reg(OFS_INT_CTRL, 8'h83);
      rd_chk(OFS_INT_STATUS, 8'h00);
   endtask
   task automatic t_data();
      fire(8'h02);
      rd_chk(OFS_INT_STATUS, 8'h02);
      rd_chk(OFS_INT_STATUS, 8'h02);
      @(negedge clk);
      touch_data_read = 1'b1;
      @(negedge clk);
      touch_data_read = 1'b0;
      rd_chk(OFS_INT_STATUS, 8'h00);
      acq_mode = 1'b1;
      fire(8'h02);
      rd_chk(OFS_INT_STATUS, 8'h02);
      rd_chk(OFS_INT_STATUS, 8'h00);
   endtask
   task automatic t_soft();
      logic seen;
      seen = 1'b0;
      wr_reg(OFS_SCRATCH_LO, 8'h5A);
      wr_reg(OFS_SYSTEM_CONTROL, 8'h40);
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         if (soft_reset === 1'b1) seen = 1'b1;
      end
      chk(8'(seen), 8'h01, "engine reset");
      rd_chk(OFS_SCRATCH_LO, 8'h00);
      rd_chk(OFS_SYSTEM_CONTROL, 8'h0F);
      rd_chk(OFS_INT_CTRL, 8'h00);
   endtask
   initial begin
      rst_n = 1'b0;
      ev = 8'h00;
      pen_down = 1'b0;
      touch_data_read = 1'b0;
      acq_mode = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_gate_scratch();
      t_role();
      t_level();
      t_edge();
      t_pen();
      t_data();
      t_soft();
      finish_test();
   end
endmodule
